// ---- hw/mapc_ctrl.sv ----
// memory reference phase controller: fetch, indirect and execute cycles on core memory
`default_nettype none
// Notes on behaviour
// - direct reference goes from fetch straight to execute and uses operand there
// - page bit zero selects base page zero, one selects the instruction's page
// - at fetch end the ten low instruction bits load address latch low bits
// - current page keeps the six upper address latch bits from the fetch
// - base page clears the six upper address latch bits
// - at execute end program counter plus one loads address latch and counter
// - indirect bit set sends fetch into the indirect phase instead of execute
// - indirect word is not executed; its fifteen low bits load the address latch
// - indirect repeats while word top bit is one, else go to execute
// - store instructions put write data into the memory data register in execute
// - read half of a write cycle does not load the memory data register
// - write half of a write cycle drives data register into the location
// - deposit switch performs the same execute write sequence as a store
// - address bits above installed capacity are ignored, accesses wrap
// - wrapped accesses raise no error and later accesses continue there
// - every read is followed by a restore write of the data register
// - in fetch the six upper word bits go to the opcode latch; not elsewhere
module mapc_ctrl #(
    parameter int CAP_BITS = mapc_pkg::CAP_BITS_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic instr_is_memref,
    input wire logic instr_is_store,
    input wire logic [15:0] store_data,
    input wire logic deposit_sw,
    input wire logic load_addr_sw,
    input wire logic [15:0] switch_reg,
    input wire logic [15:0] core_rd_data,
    output logic [14:0] core_addr,
    output logic core_read_en,
    output logic core_write_en,
    output logic [15:0] core_wr_data,
    output logic [15:0] mem_data,
    output logic [5:0] opcode,
    output logic [15:0] mem_addr,
    output logic [15:0] prog_ctr,
    output logic [1:0] phase,
    output logic operand_valid
);
    // elaboration check: the fold mask cannot serve fewer than a page of offset bits
    if (CAP_BITS < mapc_pkg::OFFS_W || CAP_BITS > mapc_pkg::ADDR_W) begin : g_cap_chk
        $error("CAP_BITS out of range");
    end

    mapc_mem_if mif ();
    mapc_cycle_seq u_seq (
        .clk(clk),
        .rst(rst),
        .mif(mif)
    );

    mapc_pkg::mapc_phase_t phase_r;
    mapc_pkg::mapc_phase_t phase_nxt;
    logic [15:0] mdr_r;
    logic [15:0] mar_r;
    logic [15:0] pc_r;
    logic [5:0] opc_r;
    logic busy_r;
    logic wr_cyc_r;
    logic dep_cyc_r;
    logic opv_r;
    logic [2:0] dep_sync_r;
    logic dep_seen_r;

    // panel switch synchroniser: three stages, change counts when last two agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) dep_sync_r <= 3'h0;
        else dep_sync_r <= {dep_sync_r[1:0], deposit_sw};
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) dep_seen_r <= 1'b0;
        else if (dep_sync_r[2] == dep_sync_r[1]) dep_seen_r <= dep_sync_r[2];
    end
    wire dep_rise = (dep_sync_r[2] == dep_sync_r[1]) && dep_sync_r[2] && !dep_seen_r;

    // folding: only installed address bits reach the core, no error flag exists
    function automatic logic [14:0] fold(input logic [15:0] a);
        logic [14:0] m;
        m = 15'h7fff >> (mapc_pkg::ADDR_W - CAP_BITS);
        fold = a[14:0] & m;
    endfunction

    wire cyc_done = mif.done;
    wire in_fetch = (phase_r == mapc_pkg::MAPC_FETCH);
    wire in_ind = (phase_r == mapc_pkg::MAPC_INDIRECT);
    wire in_exec = (phase_r == mapc_pkg::MAPC_EXECUTE);
    wire [15:0] word = mdr_r;
    wire zc_bit = word[mapc_pkg::ZC_BIT];
    wire ind_bit = word[mapc_pkg::IND_BIT];
    // phase 0 to 2 or 1 choice taken from fetched instruction word
    wire fetch_ind = instr_is_memref && ind_bit;
    wire [15:0] pc_inc = pc_r + mapc_pkg::PC_STEP;
    // operand address: upper bits kept or cleared, low ten from instruction
    wire [5:0] upper_sel = zc_bit ? mar_r[15:10] : 6'h00;
    wire [15:0] direct_addr = {upper_sel, word[9:0]};
    wire [15:0] indirect_addr = {1'b0, word[14:0]};
    wire start_ok = run && !busy_r;
    wire exec_write = instr_is_store;
    wire start_dep = !run && !busy_r && dep_rise;
    wire start_cyc = start_ok || start_dep;

    assign mif.start = start_cyc;
    assign mif.write_cycle = wr_cyc_r;

    // phase advance happens only when the memory cycle completes
    always_comb begin
        phase_nxt = phase_r;
        case (phase_r)
            mapc_pkg::MAPC_FETCH: if (cyc_done && !dep_cyc_r && instr_is_memref)
                phase_nxt = fetch_ind ? mapc_pkg::MAPC_INDIRECT
                                      : mapc_pkg::MAPC_EXECUTE;
            mapc_pkg::MAPC_INDIRECT: if (cyc_done && !dep_cyc_r)
                phase_nxt = ind_bit ? mapc_pkg::MAPC_INDIRECT
                                    : mapc_pkg::MAPC_EXECUTE;
            mapc_pkg::MAPC_EXECUTE: if (cyc_done && !dep_cyc_r)
                phase_nxt = mapc_pkg::MAPC_FETCH;
            default: phase_nxt = mapc_pkg::MAPC_FETCH;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) phase_r <= mapc_pkg::MAPC_FETCH;
        else phase_r <= phase_nxt;
    end

    // cycle bookkeeping: busy spans read and write halves
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_r <= 1'b0;
            wr_cyc_r <= 1'b0;
            dep_cyc_r <= 1'b0;
        end else if (start_cyc) begin
            busy_r <= 1'b1;
            wr_cyc_r <= start_dep || (in_exec && exec_write);
            dep_cyc_r <= start_dep;
        end else if (cyc_done) begin
            busy_r <= 1'b0;
            wr_cyc_r <= 1'b0;
            dep_cyc_r <= 1'b0;
        end
    end

    // data register: write data at start, read data only on read cycles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) mdr_r <= 16'h0000;
        else if (start_dep) mdr_r <= switch_reg;
        else if (start_ok && in_exec && exec_write) mdr_r <= store_data;
        else if (mif.read_phase && !wr_cyc_r) mdr_r <= core_rd_data;
    end

    // opcode latch loads only from a fetch-phase word, one cycle after the read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) opc_r <= mapc_pkg::OPC_RESET;
        else if (in_fetch && mif.write_phase && !dep_cyc_r)
            opc_r <= mdr_r[15:10];
    end

    // address latch and program counter load from the switches when idle, else update at cycle end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mar_r <= 16'h0000;
            pc_r <= mapc_pkg::PC_RESET;
        end else if (!run && !busy_r && load_addr_sw) begin
            mar_r <= switch_reg;
            pc_r <= switch_reg;
        end else if (cyc_done && !dep_cyc_r) begin
            if (in_fetch && instr_is_memref) mar_r <= direct_addr;
            else if (in_fetch) begin
                mar_r <= pc_inc;
                pc_r <= pc_inc;
            end else if (in_ind) mar_r <= indirect_addr;
            else begin
                mar_r <= pc_inc;
                pc_r <= pc_inc;
            end
        end
    end

    // operand valid pulse when the execute read has landed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) opv_r <= 1'b0;
        else opv_r <= in_exec && mif.read_phase && !wr_cyc_r && !dep_cyc_r;
    end

    assign core_addr = fold(mar_r);
    assign core_read_en = mif.read_phase;
    assign core_write_en = mif.write_phase;
    assign core_wr_data = mdr_r;
    assign mem_data = mdr_r;
    assign opcode = opc_r;
    assign mem_addr = mar_r;
    assign prog_ctr = pc_r;
    assign phase = phase_r;
    assign operand_valid = opv_r;

    chk_fetch_to_exec: assert property (@(posedge clk) disable iff (rst)
        in_fetch && cyc_done && !dep_cyc_r && instr_is_memref && !ind_bit
        |=> in_exec) else $error("direct fetch did not go to execute");
    chk_base_page: assert property (@(posedge clk) disable iff (rst)
        in_fetch && cyc_done && !dep_cyc_r && instr_is_memref && !zc_bit
        |=> mar_r[15:10] == 6'h00) else $error("base page not cleared");
    chk_cur_page: assert property (@(posedge clk) disable iff (rst)
        in_fetch && cyc_done && !dep_cyc_r && instr_is_memref && zc_bit
        |=> mar_r[15:10] == $past(mar_r[15:10])) else $error("page bits lost");
    chk_low_offs: assert property (@(posedge clk) disable iff (rst)
        in_fetch && cyc_done && !dep_cyc_r && instr_is_memref
        |=> mar_r[9:0] == $past(mdr_r[9:0])) else $error("offset not loaded");
    chk_pc_step: assert property (@(posedge clk) disable iff (rst)
        in_exec && cyc_done && !dep_cyc_r && !load_addr_sw
        |=> pc_r == $past(pc_r) + 16'h0001 && mar_r == pc_r)
        else $error("pc step wrong");
    chk_ind_entry: assert property (@(posedge clk) disable iff (rst)
        in_fetch && cyc_done && !dep_cyc_r && instr_is_memref && ind_bit
        |=> in_ind) else $error("indirect not entered");
    chk_ind_addr: assert property (@(posedge clk) disable iff (rst)
        in_ind && cyc_done && !dep_cyc_r |=> mar_r == {1'b0, $past(mdr_r[14:0])})
        else $error("indirect address wrong");
    chk_ind_chain: assert property (@(posedge clk) disable iff (rst)
        in_ind && cyc_done && !dep_cyc_r && !ind_bit |=> in_exec)
        else $error("indirect chain end missed");
    chk_wr_hold: assert property (@(posedge clk) disable iff (rst)
        mif.read_phase && wr_cyc_r |=> mdr_r == $past(mdr_r))
        else $error("write cycle data overwritten");
    sequence s_dep_cycle;
        start_dep ##1 mif.read_phase ##1 mif.write_phase;
    endsequence
    chk_deposit: assert property (@(posedge clk) disable iff (rst)
        start_dep |-> s_dep_cycle) else $error("deposit cycle wrong");
    chk_fold: assert property (@(posedge clk) disable iff (rst)
        core_addr == (mar_r[14:0] & (15'h7fff >> (15 - CAP_BITS))))
        else $error("fold wrong");
endmodule
`default_nettype wire

// ---- hw/mapc_pkg.sv ----
// package: constants and types for the memory reference phase controller
`default_nettype none
package mapc_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 15;
    localparam int OFFS_W = 10;
    localparam int PAGE_HI = 15;
    localparam int PAGE_LO = 10;
    localparam int IND_BIT = 15;
    localparam int ZC_BIT = 10;
    localparam int OPC_W = 6;
    localparam int CAP_BITS_DEF = 15;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [5:0] OPC_RESET = 6'h00;
    localparam logic [15:0] PC_STEP = 16'h0001;
    // memory cycle halves
    typedef enum logic [1:0] {MAPC_MC_IDLE, MAPC_MC_READ, MAPC_MC_WRITE} mapc_mc_t;
    // machine phases
    typedef enum logic [1:0] {MAPC_FETCH, MAPC_INDIRECT, MAPC_EXECUTE} mapc_phase_t;
endpackage
`default_nettype wire

// ---- hw/mapc_mem_if.sv ----
// interface: core memory cycle request and result between controller and sequencer
`default_nettype none
interface mapc_mem_if;
    logic start;
    logic write_cycle;
    logic read_phase;
    logic write_phase;
    logic done;
    modport ctrl (output start, output write_cycle, input read_phase, input write_phase,
        input done);
    modport seq (input start, input write_cycle, output read_phase, output write_phase,
        output done);
endinterface
`default_nettype wire

// ---- hw/mapc_cycle_seq.sv ----
// memory cycle sequencer: one read half then one write half per cycle
`default_nettype none
module mapc_cycle_seq (
    input wire logic clk,
    input wire logic rst,
    mapc_mem_if.seq mif
);
    mapc_pkg::mapc_mc_t st_r;
    mapc_pkg::mapc_mc_t st_nxt;

    // every cycle is read then write: a core read always needs its restore
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            mapc_pkg::MAPC_MC_IDLE: if (mif.start) st_nxt = mapc_pkg::MAPC_MC_READ;
            mapc_pkg::MAPC_MC_READ: st_nxt = mapc_pkg::MAPC_MC_WRITE;
            mapc_pkg::MAPC_MC_WRITE: st_nxt = mapc_pkg::MAPC_MC_IDLE;
            default: st_nxt = mapc_pkg::MAPC_MC_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) st_r <= mapc_pkg::MAPC_MC_IDLE;
        else st_r <= st_nxt;
    end

    assign mif.read_phase = (st_r == mapc_pkg::MAPC_MC_READ);
    assign mif.write_phase = (st_r == mapc_pkg::MAPC_MC_WRITE);
    assign mif.done = mif.write_phase;

    chk_read_then_write: assert property (@(posedge clk) disable iff (rst)
        mif.read_phase |=> mif.write_phase) else $error("read half not followed by write");
endmodule
`default_nettype wire

// ---- dv/mapc_core_mem.sv ----
// partner model: core memory stack with destructive readout
`default_nettype none
module mapc_core_mem (
    input wire logic clk,
    input wire logic [14:0] core_addr,
    input wire logic read_en,
    input wire logic write_en,
    input wire logic [15:0] wr_data,
    output logic [15:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:32767];
    logic [15:0] last_r = 16'h0000;
    // sense lines float outside the read half, so show a changing pattern
    assign rd_data = read_en ? mem[core_addr] : ~last_r;
    // readout leaves zeros; only the write half puts the word back
    always @(posedge clk) begin
        last_r <= rd_data;
        if (read_en) mem[core_addr] <= 16'h0000;
        if (write_en) mem[core_addr] <= wr_data;
    end
endmodule
`default_nettype wire

// ---- dv/mapc_ctrl_test.sv ----
// testbench: memory reference phases, store, deposit and foldover
`default_nettype none
module mapc_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, run = 1'b0, store = 1'b0, dep = 1'b0, lda = 1'b0;
    logic rden, wren, opval;
    logic [15:0] sw = 16'h0000, rd, wr, mdata, maddr, pc, opv;
    logic [14:0] caddr;
    logic [5:0] opc;
    logic [1:0] ph_o;
    logic [14:0] ra [0:7];
    logic [15:0] wd [0:7];
    logic [15:0] md [0:7];
    logic [1:0] ph [0:7];
    int fails = 0;
    int tests_run = 0;
    always #2 clk = ~clk;
    // 4K words installed so that foldover can be seen
    mapc_ctrl #(.CAP_BITS(12)) i_mapc_ctrl (.clk(clk), .rst(rst), .run(run),
        .instr_is_memref(1'b1), .instr_is_store(store), .store_data(16'ha5a5),
        .deposit_sw(dep), .load_addr_sw(lda), .switch_reg(sw), .core_rd_data(rd),
        .core_addr(caddr), .core_read_en(rden), .core_write_en(wren), .core_wr_data(wr),
        .mem_data(mdata), .opcode(opc), .mem_addr(maddr), .prog_ctr(pc), .phase(ph_o),
        .operand_valid(opval));
    mapc_core_mem i_mapc_core_mem (.clk(clk), .core_addr(caddr), .read_en(rden),
        .write_en(wren), .wr_data(wr), .rd_data(rd));
    // operand strobe lasts one cycle, so catch it wherever it lands
    always @(negedge clk) begin
        if (opval === 1'b1) opv = mdata;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // run n memory cycles, recording each read address, phase and write data
    task automatic run_cycles(input int n, input int st_at);
        int k;
        int t;
        k = 0;
        t = 0;
        opv = 16'hxxxx;
        run = 1'b1;
        while (k < n && t < 200) begin
            @(negedge clk);
            t++;
            if (rden === 1'b1) begin
                ra[k] = caddr;
                ph[k] = ph_o;
            end
            if (wren === 1'b1) begin
                wd[k] = wr;
                md[k] = mdata;
                k++;
                if (k == st_at) store = 1'b1;
                if (k == n) run = 1'b0;
            end
        end
        if (t >= 200) begin
            fails++;
            stop_test();
        end
        repeat (2) @(negedge clk);
    endtask
    task automatic load_addr(input logic [15:0] a);
        sw = a;
        lda = 1'b1;
        @(negedge clk);
        lda = 1'b0;
        repeat (2) @(negedge clk);
        check(maddr, a);
        check(pc, a);
    endtask
    task automatic t_direct();
        run_cycles(2, 0);
        check({1'b0, ra[0]}, 16'h0c05);
        check({1'b0, ra[1]}, 16'h0d23);
        check({14'h0, ph[1]}, 16'h0002);
        check(opv, 16'hbeef);
        check({10'h0, opc}, 16'h0001);
        check(maddr, 16'h0c06);
        check(pc, 16'h0c06);
        check(i_mapc_core_mem.mem[16'h0c05], 16'h0523);
        check(i_mapc_core_mem.mem[16'h0d23], 16'hbeef);
        $display("test direct done");
    endtask
    task automatic t_indirect();
        run_cycles(4, 0);
        check({1'b0, ra[1]}, 16'h0010);
        check({1'b0, ra[2]}, 16'h0200);
        check({1'b0, ra[3]}, 16'h0345);
        check({8'h0, ph[1], ph[2], ph[3]}, 16'h0016);
        check(opv, 16'h1234);
        check({10'h0, opc}, 16'h0020);
        check(pc, 16'h0c07);
        $display("test indirect done");
    endtask
    task automatic t_store();
        run_cycles(2, 1);
        store = 1'b0;
        check({1'b0, ra[1]}, 16'h0c40);
        check(md[1], 16'ha5a5);
        check(wd[1], 16'ha5a5);
        check(i_mapc_core_mem.mem[16'h0c40], 16'ha5a5);
        $display("test store done");
    endtask
    task automatic t_fold();
        run_cycles(3, 0);
        check({1'b0, ra[2]}, 16'h0345);
        check(opv, 16'h1234);
        check(pc, 16'h0c09);
        $display("test foldover done");
    endtask
    task automatic t_deposit();
        int t;
        load_addr(16'h0100);
        sw = 16'h2468;
        dep = 1'b1;
        t = 0;
        while (wren !== 1'b1 && t < 20) begin
            @(negedge clk);
            t++;
        end
        if (t >= 20) begin
            fails++;
            stop_test();
        end
        check(wr, 16'h2468);
        dep = 1'b0;
        repeat (3) @(negedge clk);
        check(i_mapc_core_mem.mem[16'h0100], 16'h2468);
        check({14'h0, ph_o}, 16'h0000);
        $display("test deposit done");
    endtask
    initial begin
        i_mapc_core_mem.mem[16'h0c05] = 16'h0523;
        i_mapc_core_mem.mem[16'h0d23] = 16'hbeef;
        i_mapc_core_mem.mem[16'h0c06] = 16'h8010;
        i_mapc_core_mem.mem[16'h0010] = 16'h8200;
        i_mapc_core_mem.mem[16'h0200] = 16'h0345;
        i_mapc_core_mem.mem[16'h0345] = 16'h1234;
        i_mapc_core_mem.mem[16'h0c07] = 16'h0c40;
        i_mapc_core_mem.mem[16'h0c40] = 16'h5555;
        i_mapc_core_mem.mem[16'h0c08] = 16'h8011;
        i_mapc_core_mem.mem[16'h0011] = 16'h7345;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        load_addr(16'h0c05);
        t_direct();
        t_indirect();
        t_store();
        t_fold();
        t_deposit();
        stop_test();
    end
endmodule
`default_nettype wire
